// >>> hw/card_glue_defines.svh
// address map, field positions, reset values and counts of the card glue
`ifndef CARD_GLUE_DEFINES_SVH
`define CARD_GLUE_DEFINES_SVH
// =========================================
// subsystem addresses
`define SS_ATTR_LAST  9'h107
`define SS_CTRL_ADDR  9'h110
`define SS_DIV_ADDR   9'h120
`define SS_MCR5_ADDR  9'h130
`define SS_FCR_ADDR   9'h132
`define SS_MCR_ADDR   9'h134
`define SS_BYP_ADDR   9'h140
// =========================================
// subsystem control fields
`define CTRL_RESET    8'h22
`define CTRL_COM_LO   0
`define CTRL_COM_HI   1
`define CTRL_STS_EN   2
`define CTRL_ADR_MODE 3
`define CTRL_READY    4
`define CTRL_MEM_CARD 5
`define CTRL_IRQ_CLR  6
`define CTRL_BYPASS   7
// =========================================
// uart register fields
`define UART_FCR_REG  3'h2
`define UART_MCR_REG  3'h4
`define FCR_AUTO_RTS  4
`define FCR_DEEP      5
`define FCR_ALWAYS1   8'h06
`define MCR_AUTO_CTS  5
`define TRIG64_0      6'h01
`define TRIG64_1      6'h10
`define TRIG64_2      6'h20
`define TRIG64_3      6'h38
`define TRIG16_0      6'h01
`define TRIG16_1      6'h04
`define TRIG16_2      6'h08
`define TRIG16_3      6'h0e
// =========================================
// divider counts
`define DIV_OFF       6'h00
`define DIV_MIN       6'h04
`define DIV_LONG_INT  5'h08
`define LOW_SHORT     5'h01
`define LOW_LONG      5'h04
`endif

// >>> hw/card_glue_pkg.sv
// types shared by the card glue modules
package card_glue_pkg;
  // =========================================
  // host side request signals
  typedef struct packed {
    logic [8:0] mem_addr;
    logic       mem_wr;
    logic       mem_rd;
    logic [9:0] io_addr;
    logic       iord_n;
    logic       iowr_n;
    logic       ce1_n;
    logic       ce2_n;
    logic       reg_n;
    logic [7:0] io_wdata;
  } host_req_t;
  // subsystem side request signals
  typedef struct packed {
    logic [8:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } ss_req_t;
  // uart strobes toward the core
  typedef struct packed {
    logic       sel;
    logic       rd;
    logic       wr;
    logic [2:0] reg_addr;
  } uart_acc_t;
endpackage

// >>> hw/arb_clock_div.sv
// arbitration clock divider by 1, 2, 4 or 8
`include "card_glue_defines.svh"
module arb_clock_div (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_arb_divider_sel_lo,
  input  wire logic       i_arb_divider_sel_hi,
  output logic            o_tick,
  output logic            o_arbitration_clock_out
);
  logic [2:0] cnt_reg;
  logic [2:0] mask;
  logic       tick_reg;

  // code LL,LH,HL,HH gives divide 1,2,4,8 [RULE23]
  always_comb begin
    case ({i_arb_divider_sel_hi, i_arb_divider_sel_lo})
      2'b00:   mask = 3'h0;
      2'b01:   mask = 3'h1;
      2'b10:   mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  // free counter, tick on each divided period [RULE23]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg  <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= (cnt_reg & mask) == mask ? 3'h0 : cnt_reg + 3'h1;
      tick_reg <= (cnt_reg & mask) == mask;
    end
  end

  assign o_tick = tick_reg;
  // divide by one passes the input clock through
  assign o_arbitration_clock_out = (mask == 3'h0) ? i_ref_clk :
    ((cnt_reg & mask) <= (mask >> 1));
endmodule // arb_clock_div

// >>> hw/half_step_div.sv
// divide-by-n-and-a-half clock for the uart
`include "card_glue_defines.svh"
module half_step_div (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_restart,
  input  wire logic [5:0] i_divisor,
  output logic            o_clk
);
  logic [5:0] cnt_reg;
  logic [4:0] n;
  logic [4:0] low;
  logic [5:0] last;
  logic       a_reg;
  logic       b_reg;
  logic       neg_reg;
  logic       half;

  assign n    = i_divisor[5:1];          // whole part
  assign half = i_divisor[0];            // half step [RULE19]
  assign low  = (n >= `DIV_LONG_INT) ? `LOW_LONG : `LOW_SHORT; // [RULE20] [RULE21]
  // half steps run two output periods in 2n+1 cycles
  assign last = half ? {n, 1'b0} : {1'b0, n} - 6'h01;

  // period counter and low windows, restarted by a divisor write
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 6'h00;
      a_reg   <= 1'b0;
      b_reg   <= 1'b0;
    end else if (i_restart) begin // [RULE18]
      cnt_reg <= 6'h00;
      a_reg   <= 1'b0;
      b_reg   <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg >= last) ? 6'h00 : cnt_reg + 6'h01;
      a_reg   <= (cnt_reg < {1'b0, low}) | (half &
        (cnt_reg > {1'b0, n}) & (cnt_reg <= {1'b0, n} + {1'b0, low}));
      b_reg   <= (cnt_reg < {1'b0, low}) | (half &
        (cnt_reg >= {1'b0, n}) & (cnt_reg < {1'b0, n} + {1'b0, low}));
    end
  end

  // falling-edge copy stretches a low pulse by half a cycle
  always_ff @(negedge i_ref_clk or posedge i_rst) begin
    if (i_rst) neg_reg <= 1'b0;
    else       neg_reg <= b_reg;
  end

  // zero holds high, 1 to 3 pass the clock [RULE19] [RULE22]
  assign o_clk = (i_divisor == `DIV_OFF) ? 1'b1 :
    (i_divisor < `DIV_MIN) ? i_ref_clk : ~(a_reg | (half & neg_reg));
endmodule // half_step_div

// >>> hw/card_uart_glue.sv
// glue between host card port, subsystem and the uart
`include "card_glue_defines.svh"
// Behaviour
// (RULE1) same-address double write keeps host write
// (RULE2) host attribute write raises subsystem notification
// (RULE3) control bit 6 clears notification, self-clearing
// (RULE4) bit 2 lets subsystem writes assert status-change
// (RULE5) host attribute read deasserts status-change
// (RULE6) flags change only on arbitration clock ticks
// (RULE7) colliding write beats read; notification alike
// (RULE8) address mode decodes COM port address bits
// (RULE9) card enables with REG select when present
// (RULE10) extend-inhibit low enables auto-RTS, deep FIFO
// (RULE11) deep mode triggers 1, 16, 32, 56
// (RULE12) modem control bit 5 subsystem-written only
// (RULE13) subsystem readback of modem and FIFO control
// (RULE14) control bits 1:0 pick COM, COM2 default
// (RULE15) control bit 3 enables address mode
// (RULE16) bits 5:4 set card type and IREQ
// (RULE17) control bit 7 enables serial bypass
// (RULE18) divisor write resets uart and divider
// (RULE19) divisor in half steps up to 31.5
// (RULE20) short low time below divisor eight
// (RULE21) four-cycle low time from divisor eight
// (RULE22) zero stops clock, 1 to 3 divide one
// (RULE23) arbitration clock divide by 1,2,4,8
// (RULE24) bypass address writes rx, reads tx FIFO
// (RULE25) control bit 6 reads back zero
module card_uart_glue (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst,
  input  wire card_glue_pkg::host_req_t  i_host,
  input  wire card_glue_pkg::ss_req_t    i_ss,
  input  wire logic                      i_card_en_present,
  input  wire logic                      i_extend_inhibit,
  input  wire logic                      i_arb_divider_sel_lo,
  input  wire logic                      i_arb_divider_sel_hi,
  input  wire logic                      i_uart_intr,
  input  wire logic [7:0]                i_bypass_tx_data,
  output card_glue_pkg::uart_acc_t       o_uart,
  output logic                           o_ss_mem_wr,
  output logic                           o_host_write_irq,
  output logic                           o_status_change_n,
  output logic                           o_ireq,
  output logic                           o_auto_rts,
  output logic                           o_fifo_deep,
  output logic [5:0]                     o_rx_trigger_level,
  output logic                           o_auto_cts,
  output logic                           o_uart_reset,
  output logic                           o_bypass_rx_wr,
  output logic                           o_bypass_tx_rd,
  output logic [7:0]                     o_bypass_wdata,
  output logic [7:0]                     o_ss_rdata,
  output logic                           o_divided_serial_clock,
  output logic                           o_arbitration_clock_out
);
  // =========================================
  // declarations
  logic [7:0] ctrl_reg;
  logic [7:0] fcr_reg;
  logic [7:0] mcr_reg;
  logic [5:0] div_reg;
  logic       restart_reg;
  logic       tick;
  logic       h_wr_pend_reg;
  logic       h_rd_pend_reg;
  logic       s_wr_pend_reg;
  logic       clr_pend_reg;
  logic       irq_reg;
  logic       sts_n_reg;
  logic       ss_attr;
  logic       ss_wr_ctrl;
  logic       addr_hit;
  logic       ce_hit;
  logic       sel;
  logic [7:0] fcr_view;
  logic [7:0] rdata_next;
  card_glue_pkg::uart_acc_t uart_reg;
  card_glue_pkg::uart_acc_t uart_next;

  assign ss_attr    = i_ss.addr <= `SS_ATTR_LAST;
  assign ss_wr_ctrl = i_ss.wr & (i_ss.addr == `SS_CTRL_ADDR);

  // =========================================
  // arbitration clock [RULE23]
  arb_clock_div u_arb (
    .i_ref_clk               (i_ref_clk),
    .i_rst                   (i_rst),
    .i_arb_divider_sel_lo    (i_arb_divider_sel_lo),
    .i_arb_divider_sel_hi    (i_arb_divider_sel_hi),
    .o_tick                  (tick),
    .o_arbitration_clock_out (o_arbitration_clock_out)
  );

  // =========================================
  // attribute memory write arbitration
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) o_ss_mem_wr <= 1'b0;
    else       o_ss_mem_wr <= i_ss.wr & ss_attr & ~(i_host.mem_wr &
                  (i_host.mem_addr == i_ss.addr)); // [RULE1]
  end

  // =========================================
  // handshake events wait for the next arbitration tick
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      h_wr_pend_reg <= 1'b0;
      h_rd_pend_reg <= 1'b0;
      s_wr_pend_reg <= 1'b0;
      clr_pend_reg  <= 1'b0;
    end else begin
      // a new event in a tick cycle is kept, not dropped
      h_wr_pend_reg <= i_host.mem_wr | (h_wr_pend_reg & ~tick); // [RULE6]
      h_rd_pend_reg <= i_host.mem_rd | (h_rd_pend_reg & ~tick);
      s_wr_pend_reg <= (i_ss.wr & ss_attr & ctrl_reg[`CTRL_STS_EN]) |
                       (s_wr_pend_reg & ~tick); // [RULE4]
      clr_pend_reg  <= (ss_wr_ctrl & i_ss.wdata[`CTRL_IRQ_CLR]) |
                       (clr_pend_reg & ~tick); // [RULE3]
    end
  end

  // notification flag, set beats clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)                      irq_reg <= 1'b0;
    else if (tick & h_wr_pend_reg)  irq_reg <= 1'b1; // [RULE2] [RULE7]
    else if (tick & clr_pend_reg)   irq_reg <= 1'b0; // [RULE3]
  end

  // status change, write beats a read in the same tick
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)                      sts_n_reg <= 1'b1;
    else if (tick & s_wr_pend_reg)  sts_n_reg <= 1'b0; // [RULE4] [RULE7]
    else if (tick & h_rd_pend_reg)  sts_n_reg <= 1'b1; // [RULE5]
  end

  assign o_host_write_irq  = irq_reg;
  assign o_status_change_n = sts_n_reg;

  // =========================================
  // subsystem control and divisor writes
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= `CTRL_RESET; // [RULE14] [RULE15] [RULE16] [RULE17]
    end else if (ss_wr_ctrl) begin
      ctrl_reg <= i_ss.wdata;
      ctrl_reg[`CTRL_IRQ_CLR] <= 1'b0; // [RULE3] [RULE25]
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      div_reg     <= `DIV_OFF;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= i_ss.wr & (i_ss.addr == `SS_DIV_ADDR); // [RULE18]
      if (i_ss.wr & (i_ss.addr == `SS_DIV_ADDR)) div_reg <= i_ss.wdata[5:0];
    end
  end

  assign o_uart_reset = restart_reg;

  // =========================================
  // uart select decode
  assign addr_hit = ctrl_reg[`CTRL_ADR_MODE] &
    (i_host.io_addr[9:5] == {1'b1, ~ctrl_reg[`CTRL_COM_HI], 3'b111}) &
    (i_host.io_addr[4] == ~ctrl_reg[`CTRL_COM_LO]) &
    i_host.io_addr[3]; // [RULE8] [RULE14] [RULE15]
  assign ce_hit = (~i_host.ce1_n | ~i_host.ce2_n) & ~i_host.reg_n; // [RULE9]
  assign sel = ~ctrl_reg[`CTRL_MEM_CARD] &
    (i_card_en_present ? ce_hit : addr_hit); // [RULE9] [RULE16]

  always_comb begin
    uart_next.sel      = sel;
    uart_next.rd       = sel & ~i_host.iord_n; // [RULE9]
    uart_next.wr       = sel & ~i_host.iowr_n;
    uart_next.reg_addr = i_host.io_addr[2:0]; // [RULE8]
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) uart_reg <= '0;
    else       uart_reg <= uart_next;
  end

  assign o_uart = uart_reg;

  // =========================================
  // host shadows of fifo and modem control
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fcr_reg <= 8'h00;
    end else if (uart_next.wr & (uart_next.reg_addr == `UART_FCR_REG)) begin
      fcr_reg <= i_host.io_wdata;
    end
  end

  // bit 5 of modem control ignores the host [RULE12]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mcr_reg <= 8'h00;
    end else begin
      if (uart_next.wr & (uart_next.reg_addr == `UART_MCR_REG)) begin
        mcr_reg[4:0] <= i_host.io_wdata[4:0];
        mcr_reg[7:6] <= i_host.io_wdata[7:6];
      end
      if (i_ss.wr & (i_ss.addr == `SS_MCR5_ADDR)) begin
        mcr_reg[`MCR_AUTO_CTS] <= i_ss.wdata[`MCR_AUTO_CTS]; // [RULE12]
      end
    end
  end

  // fifo mode and trigger level from the shadow
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_auto_rts         <= 1'b0;
      o_fifo_deep        <= 1'b0;
      o_rx_trigger_level <= `TRIG16_0;
      o_auto_cts         <= 1'b0;
      o_ireq             <= 1'b0;
    end else begin
      o_auto_rts  <= fcr_reg[`FCR_AUTO_RTS] & ~i_extend_inhibit; // [RULE10]
      o_fifo_deep <= fcr_reg[`FCR_DEEP] & ~i_extend_inhibit; // [RULE10]
      o_auto_cts  <= mcr_reg[`MCR_AUTO_CTS]; // [RULE12]
      if (fcr_reg[`FCR_DEEP] & ~i_extend_inhibit) begin
        case (fcr_reg[7:6]) // [RULE11]
          2'b00:   o_rx_trigger_level <= `TRIG64_0;
          2'b01:   o_rx_trigger_level <= `TRIG64_1;
          2'b10:   o_rx_trigger_level <= `TRIG64_2;
          default: o_rx_trigger_level <= `TRIG64_3;
        endcase
      end else begin
        case (fcr_reg[7:6])
          2'b00:   o_rx_trigger_level <= `TRIG16_0;
          2'b01:   o_rx_trigger_level <= `TRIG16_1;
          2'b10:   o_rx_trigger_level <= `TRIG16_2;
          default: o_rx_trigger_level <= `TRIG16_3;
        endcase
      end
      // memory card shows ready/busy, io card the interrupt [RULE16]
      o_ireq <= ctrl_reg[`CTRL_MEM_CARD] ? ctrl_reg[`CTRL_READY]
                                          : i_uart_intr;
    end
  end

  // =========================================
  // subsystem readback
  always_comb begin
    fcr_view = fcr_reg | `FCR_ALWAYS1; // [RULE13]
    fcr_view[`FCR_AUTO_RTS] = ~(fcr_reg[`FCR_AUTO_RTS] & ~i_extend_inhibit);
    fcr_view[`FCR_DEEP]     = ~(fcr_reg[`FCR_DEEP] & ~i_extend_inhibit);
    case (i_ss.addr)
      `SS_CTRL_ADDR: rdata_next = ctrl_reg; // [RULE25]
      `SS_FCR_ADDR:  rdata_next = fcr_view; // [RULE13]
      `SS_MCR_ADDR:  rdata_next = mcr_reg;  // [RULE13]
      `SS_BYP_ADDR:  rdata_next = ctrl_reg[`CTRL_BYPASS] ?
                                  i_bypass_tx_data : 8'h00; // [RULE24]
      default:       rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)        o_ss_rdata <= 8'h00;
    else if (i_ss.rd) o_ss_rdata <= rdata_next;
  end

  // =========================================
  // serial bypass strobes
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bypass_rx_wr <= 1'b0;
      o_bypass_tx_rd <= 1'b0;
      o_bypass_wdata <= 8'h00;
    end else begin
      o_bypass_rx_wr <= ctrl_reg[`CTRL_BYPASS] & i_ss.wr &
                        (i_ss.addr == `SS_BYP_ADDR); // [RULE17] [RULE24]
      o_bypass_tx_rd <= ctrl_reg[`CTRL_BYPASS] & i_ss.rd &
                        (i_ss.addr == `SS_BYP_ADDR); // [RULE24]
      if (i_ss.wr) o_bypass_wdata <= i_ss.wdata;
    end
  end

  // =========================================
  // uart clock divider [RULE19] [RULE20] [RULE21] [RULE22]
  half_step_div u_div (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_restart (restart_reg),
    .i_divisor (div_reg),
    .o_clk     (o_divided_serial_clock)
  );

  // =========================================
  // checks
  a_host_write_wins: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_host.mem_wr & i_ss.wr & (i_host.mem_addr == i_ss.addr))
    |=> !o_ss_mem_wr) else $error("subsystem write not dropped"); // [RULE1]
  a_irq_raise: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (tick & h_wr_pend_reg) |=> o_host_write_irq)
    else $error("notification not raised"); // [RULE2]
  a_irq_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (tick & clr_pend_reg & !h_wr_pend_reg) |=> !o_host_write_irq)
    else $error("notification not cleared"); // [RULE3]
  a_ctrl6_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ss_wr_ctrl |=> !ctrl_reg[`CTRL_IRQ_CLR])
    else $error("control bit 6 held"); // [RULE25]
  a_sts_assert: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ss.wr & ss_attr & ctrl_reg[`CTRL_STS_EN]) |-> ##[1:9] !o_status_change_n)
    else $error("status change not asserted"); // [RULE4]
  a_sts_write_wins: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (tick & s_wr_pend_reg & h_rd_pend_reg) |=> !o_status_change_n)
    else $error("read beat write"); // [RULE7]
  a_flags_on_tick: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !tick |=> $stable(o_status_change_n) && $stable(o_host_write_irq))
    else $error("flag changed off tick"); // [RULE6]
  a_uart_io_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ctrl_reg[`CTRL_MEM_CARD] |=> !o_uart.sel)
    else $error("uart selected on memory card"); // [RULE16]
  a_div_restart: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ss.wr & (i_ss.addr == `SS_DIV_ADDR)) |=> o_uart_reset ##1 !o_uart_reset)
    else $error("divisor write gave no reset pulse"); // [RULE18]
  a_mcr5_host_ro: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !(i_ss.wr & (i_ss.addr == `SS_MCR5_ADDR)) |=> $stable(mcr_reg[5]))
    else $error("modem bit 5 changed by host"); // [RULE12]
endmodule // card_uart_glue

// >>> dv/ss_model.sv
// subsystem microcontroller bus model for the card glue
`include "card_glue_defines.svh"
module ss_model (
  input  wire logic                 i_ref_clk,
  input  wire logic [7:0]           i_rdata,
  output card_glue_pkg::ss_req_t    o_ss
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_ss = '0;
  // one write, held over the sampling edge; data line then scrambled
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_ss = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge i_ref_clk);
    o_ss.wr = 1'b0;
    o_ss.wdata = ~d;
  endtask
  // one read; data taken after the registered answer settles
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(negedge i_ref_clk);
    o_ss = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge i_ref_clk);
    o_ss.rd = 1'b0;
    @(negedge i_ref_clk);
    d = i_rdata;
  endtask
  // notification clear: a one into bit 6, other bits kept
  task automatic clr_irq(input logic [7:0] c);
    wr(`SS_CTRL_ADDR, c | 8'h40);
  endtask
  // auto-cts bit is only ever written from this side
  task automatic set_cts(input logic b);
    wr(`SS_MCR5_ADDR, {2'b00, b, 5'h00});
  endtask
endmodule // ss_model

// >>> dv/testbench.sv
// self-checking bench for the card glue
`include "card_glue_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, cen, ext, sel_lo, sel_hi, uintr, ss_wr, irq, sts_n;
  logic ireq, arts, deep, acts, urst, brx, btx, dsc, aco;
  logic [7:0] txd, bwd, rdata;
  logic [5:0] trig;
  card_glue_pkg::host_req_t host;
  card_glue_pkg::ss_req_t   ss;
  card_glue_pkg::uart_acc_t uart;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  int nwr = 0, nrst = 0, nbrx = 0, nbtx = 0;
  integer seed;

  card_uart_glue card_uart_glue_i (.i_ref_clk(clk), .i_rst(rst),
    .i_host(host), .i_ss(ss), .i_card_en_present(cen),
    .i_extend_inhibit(ext), .i_arb_divider_sel_lo(sel_lo),
    .i_arb_divider_sel_hi(sel_hi), .i_uart_intr(uintr),
    .i_bypass_tx_data(txd), .o_uart(uart), .o_ss_mem_wr(ss_wr),
    .o_host_write_irq(irq), .o_status_change_n(sts_n), .o_ireq(ireq),
    .o_auto_rts(arts), .o_fifo_deep(deep), .o_rx_trigger_level(trig),
    .o_auto_cts(acts), .o_uart_reset(urst), .o_bypass_rx_wr(brx),
    .o_bypass_tx_rd(btx), .o_bypass_wdata(bwd), .o_ss_rdata(rdata),
    .o_divided_serial_clock(dsc), .o_arbitration_clock_out(aco));
  ss_model ss_model_i (.i_ref_clk(clk), .i_rdata(rdata), .o_ss(ss));

  // clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // pulse counters, sampled where outputs are settled
  always @(negedge clk) begin
    if (ss_wr === 1'b1) nwr++;
    if (urst === 1'b1) nrst++;
    if (brx === 1'b1) nbrx++;
    if (btx === 1'b1) nbtx++;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // =====================================
  // shared tasks
  task automatic chk(input string s, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // flag latency is at most 2 + 8 cycles
  task automatic settle();
    repeat (12) @(negedge clk);
  endtask
  task automatic hmem(input logic w, input logic [8:0] ad);
    @(negedge clk);
    host.mem_addr = ad;
    host.mem_wr = w;
    host.mem_rd = ~w;
    @(negedge clk);
    host.mem_wr = 1'b0;
    host.mem_rd = 1'b0;
  endtask
  // host i/o cycle, returns the uart strobes one cycle in
  task automatic hio(input logic w, input logic [9:0] ad,
    input logic [7:0] dt, output card_glue_pkg::uart_acc_t u);
    @(negedge clk);
    host.io_addr = ad;
    host.io_wdata = dt;
    host.iowr_n = ~w;
    host.iord_n = w;
    @(negedge clk);
    u = uart;
    @(negedge clk);
    host.iowr_n = 1'b1;
    host.iord_n = 1'b1;
    host.io_wdata = ~dt;
  endtask
  function automatic logic [5:0] trig_exp(input logic [7:0] f, input logic x);
    logic [5:0] dp[4] = '{6'h01, 6'h10, 6'h20, 6'h38};
    logic [5:0] sd[4] = '{`TRIG16_0, `TRIG16_1, `TRIG16_2, `TRIG16_3};
    return (~x & f[5]) ? dp[f[7:6]] : sd[f[7:6]];
  endfunction
  // divisor write, restart pulse, then period and low time
  task automatic div_chk(input logic [5:0] v);
    time t[5];
    int  n;
    n = nrst;
    ss_model_i.wr(`SS_DIV_ADDR, {2'b00, v});
    @(negedge clk);
    chk("uart_reset", 1, nrst - n);
    if (v == 6'h00) begin
      repeat (40) @(negedge clk) chk("div_stop", 1, dsc);
    end else begin
      repeat (2) @(negedge dsc);
      foreach (t[i]) begin
        if (i % 2 == 0) @(negedge dsc); else @(posedge dsc);
        t[i] = $time;
      end
      chk("div_pair", v < 4 ? 100 : 50 * v, 32'(t[4] - t[0]));
      n = (v < 16 ? 50 : 200) + (v[0] ? 25 : 0);
      if (v >= 4) chk("low_a", n, 32'(t[1] - t[0]));
      if (v >= 4) chk("low_b", n, 32'(t[3] - t[2]));
    end
  endtask

  // =====================================
  // main sequence
  initial begin
    logic [7:0] d, q, ctrl;
    logic [8:0] a;
    logic [9:0] base;
    logic [2:0] r;
    time t;
    int n;
    card_glue_pkg::uart_acc_t u;
    logic [5:0] dv[9] = '{6'h00, 6'h02, 6'h04, 6'h05, 6'h0f, 6'h10,
                          6'h11, 6'h3f, 6'h10};
    seed = 32'h5265_f4ed;
    host = '0;
    {host.iord_n, host.iowr_n, host.ce2_n} = 3'h7;
    {cen, ext, uintr, txd, rst} = {3'b110, 8'h00, 1'b1};
    {sel_hi, sel_lo} = 2'($random(seed));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    ctrl = 8'h22;
    ss_model_i.rd(`SS_CTRL_ADDR, d);
    chk("ctrl_reset", ctrl, d);
    chk("flags", 4'h5, {irq, sts_n, ireq, dsc});
    hio(1'b0, 10'h005, 8'h00, u);
    chk("sel_mem_card", 0, u.sel);
    for (int i = 0; i < 5; i++) begin
      if (i < 4) {sel_hi, sel_lo} = 2'(i);
      else {sel_hi, sel_lo} = 2'($random(seed));
      repeat (9) @(negedge clk);
      @(posedge aco);
      t = $time;
      @(posedge aco);
      chk("arb_period", 50 << {sel_hi, sel_lo}, 32'($time - t));
    end
    a = {1'b0, 8'($random(seed))};
    hmem(1'b1, a);
    settle();
    chk("irq_set", 1, irq);
    ss_model_i.clr_irq(ctrl);
    settle();
    chk("irq_clear", 0, irq);
    ss_model_i.rd(`SS_CTRL_ADDR, d);
    chk("ctrl_bit6", ctrl, d);
    fork
      hmem(1'b1, a);
      ss_model_i.clr_irq(ctrl);
    join
    settle();
    chk("irq_collide", 1, irq);
    ss_model_i.wr(a, 8'h5a);
    settle();
    chk("sts_off", 1, sts_n);
    ctrl = ctrl | 8'h04;
    ss_model_i.wr(`SS_CTRL_ADDR, ctrl);
    for (int i = 0; i < 2; i++) begin
      fork
        ss_model_i.wr(a, 8'h3c);
        if (i == 1) hmem(1'b0, a);
      join
      settle();
      chk("sts_set", 0, sts_n);
      hmem(1'b0, a);
      settle();
      chk("sts_clear", 1, sts_n);
    end
    for (int i = 0; i < 2; i++) begin
      n = nwr;
      fork
        ss_model_i.wr(a ^ 9'(i), 8'h77);
        hmem(1'b1, a);
      join
      settle();
      chk("ss_mem_wr", i, nwr - n);
    end
    // ready first, then switch to an i/o card
    ctrl = ctrl | 8'h10;
    ss_model_i.wr(`SS_CTRL_ADDR, ctrl);
    settle();
    chk("ireq_ready", 1, ireq);
    ctrl = ctrl & 8'hdf;
    ss_model_i.wr(`SS_CTRL_ADDR, ctrl);
    for (int i = 0; i < 2; i++) begin
      uintr = i[0];
      settle();
      chk("ireq_intr", i, ireq);
    end
    for (int i = 0; i < 3; i++) begin
      {host.ce2_n, host.ce1_n} = 2'(i + 1);
      r = 3'($random(seed));
      hio(1'b0, {7'h00, r}, 8'h00, u);
      chk("sel_card", {i < 2, i < 2, 1'b0}, {u.sel, u.rd, u.wr});
      if (i < 2) chk("reg_card", r, u.reg_addr);
    end
    host.ce1_n = 1'b0;
    for (int i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      ext = (i < 4) ? 1'b0 : 1'($random(seed));
      if (i < 4) d[7:5] = {i[1:0], 1'b1};
      hio(1'b1, 10'h002, d, u);
      chk("fcr_strobe", 2'b11, {u.sel, u.wr});
      repeat (3) @(negedge clk);
      chk("fifo_mode", {~ext & d[5], ~ext & d[4]}, {deep, arts});
      chk("trigger", trig_exp(d, ext), trig);
      ss_model_i.rd(`SS_FCR_ADDR, q);
      chk("fcr_read", {2'b00, ~(~ext & d[5]), ~(~ext & d[4]), 4'h6},
          q & 8'h36);
    end
    for (int i = 1; i >= 0; i--) begin
      ss_model_i.set_cts(i[0]);
      hio(1'b1, 10'h004, {2'b00, ~i[0], 5'h00}, u);
      repeat (3) @(negedge clk);
      chk("auto_cts", i, acts);
      ss_model_i.rd(`SS_MCR_ADDR, q);
      chk("mcr_read", i, q[5]);
    end
    {cen, host.ce1_n, host.reg_n} = 3'b011;
    for (int c = 0; c < 5; c++) begin
      if (c < 4) ctrl = {ctrl[7:4], 1'b1, ctrl[2], 2'(c)};
      else ctrl[3] = 1'b0;
      ss_model_i.wr(`SS_CTRL_ADDR, ctrl);
      r = 3'($random(seed));
      base = {1'b1, ~ctrl[1], 3'b111, ~ctrl[0], 1'b1, r};
      hio(1'b0, base, 8'h00, u);
      chk("sel_addr", c < 4, u.sel);
      if (c < 4) chk("reg_addr", r, u.reg_addr);
      hio(1'b0, base ^ 10'h100, 8'h00, u);
      chk("sel_other", 0, u.sel);
    end
    for (int i = 0; i < 2; i++) begin
      n = nbrx;
      d = 8'($random(seed));
      ss_model_i.wr(`SS_BYP_ADDR, d);
      settle();
      chk("bypass_wr", i, nbrx - n);
      if (i == 0) begin
        ctrl[7] = 1'b1;
        ss_model_i.wr(`SS_CTRL_ADDR, ctrl);
      end
    end
    chk("bypass_data", d, bwd);
    txd = 8'($random(seed));
    n = nbtx;
    ss_model_i.rd(`SS_BYP_ADDR, q);
    chk("bypass_rd", {txd, 8'h01}, {q, 8'(nbtx - n)});
    // mid-run reset brings back defaults and idle flags
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    ss_model_i.rd(`SS_CTRL_ADDR, d);
    chk("rerst", {8'h22, 2'b01}, {d, irq, sts_n});
    dv[8] = 6'($random(seed)) | 6'h10;
    foreach (dv[i]) div_chk(dv[i]);
    report_and_stop();
  end
endmodule // testbench
